// [logic/plsp_pkg.sv]
// plsp_pkg: opcodes, state timing and carriers for the pair load and stack pop engine
// assumes one processor clock; the memory answers a read in the cycle it is asked
package plsp_pkg;
  localparam logic [7:0] OPC_LOAD_PRIMARY     = 8'h2A;
  localparam logic [7:0] OPC_PREFIX_EXT       = 8'hED;
  localparam logic [7:0] OPC_EXT_LOAD_PRIMARY = 8'h6B;
  localparam logic [7:0] OPC_POP_BASE         = 8'hC1;
  localparam logic [7:0] OPC_POP_MASK         = 8'hCF;
  localparam logic [7:0] OPC_PREFIX_FIRST_IDX = 8'hDD;
  localparam logic [7:0] OPC_PREFIX_SECOND_IDX = 8'hFD;
  localparam logic [7:0] OPC_POP_INDEX        = 8'hE1;
  localparam int unsigned POP_SEL_LSB         = 4;
  localparam int unsigned IDX_SEL_BIT         = 5;
  // clock states per machine cycle
  localparam logic [2:0] T_OPFETCH = 3'h4;
  localparam logic [2:0] T_MEMRD   = 3'h3;
  localparam logic [15:0] RESET_PAIR = 16'h0000;
  localparam logic [15:0] RESET_SP   = 16'hFFFF;

  typedef enum {
    PLSP_IDLE, PLSP_PREFIX, PLSP_OPN_LO, PLSP_OPN_HI, PLSP_DATA_LO, PLSP_DATA_HI
  } plsp_state_e;

  typedef enum logic [2:0] {
    PLSP_GEN_ONE, PLSP_GEN_TWO, PLSP_PRIMARY, PLSP_ACCFLAGS, PLSP_IDX_FIRST, PLSP_IDX_SECOND
  } plsp_dest_e;

  // memory read request towards the program/stack memory
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } plsp_memreq_s;

  // all destination pairs visible to the rest of the core
  typedef struct packed {
    logic [15:0] genPairOne;
    logic [15:0] genPairTwo;
    logic [15:0] primaryAddressPair;
    logic [15:0] accumFlagsPair;
    logic [15:0] firstIndexReg;
    logic [15:0] secondIndexReg;
    logic [15:0] stackPointerReg;
  } plsp_regs_s;
endpackage

// [logic/plsp_core.sv]
// plsp_core: executes absolute pair loads and stack pops one machine cycle at a time
// assumes memory returns memData in the same cycle as memReq.rd, program counter is held here
// assumes memory runs on clk, so memData is same-domain logic and passes no synchroniser
`timescale 1ns/1ps
module plsp_core (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic [7:0]            memData,
  output plsp_pkg::plsp_memreq_s     memReq,
  output plsp_pkg::plsp_regs_s       regs,
  output logic [15:0]                progCounter,
  output logic                       busy,
  output logic                       instrDone,
  output logic                       illegalOp
);
  logic                  rstMeta;
  logic                  rstSync;
  plsp_pkg::plsp_state_e stateReg;
  plsp_pkg::plsp_dest_e  destReg;
  logic [2:0]            tcountReg;
  logic [2:0]            tlenReg;
  logic                  fetchReg;
  logic [15:0]           addrReg;
  logic [7:0]            loByteReg;
  logic [15:0]           pairValue;
  logic                  cycleEnd;
  // set for pops only, so a completed absolute load leaves the stack pointer alone
  logic                  popReg;
  logic                  pairWrite;

  // reset released through two flops so release is clean to clk
  // every other flop is reset from the synchronised copy, never from the pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // a machine cycle ends on its last clock state; data is sampled there
  // busy stays high: the engine is always inside an instruction or its opcode fetch
  assign cycleEnd = (tcountReg == tlenReg - 3'h1);
  assign busy     = (stateReg != plsp_pkg::PLSP_IDLE) || fetchReg;
  assign pairValue = {memData, loByteReg};
  assign pairWrite = cycleEnd && (stateReg == plsp_pkg::PLSP_DATA_HI);

  // clock state counter within the current machine cycle
  // tlenReg changes only at a cycle end, so the counter never runs past it
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      tcountReg <= 3'h0;
    end else if (cycleEnd) begin
      tcountReg <= 3'h0;
    end else begin
      tcountReg <= tcountReg + 3'h1;
    end
  end

  // sequencer: decodes fetched bytes and walks the memory cycles
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      stateReg    <= plsp_pkg::PLSP_IDLE;
      destReg     <= plsp_pkg::PLSP_GEN_ONE;
      tlenReg     <= plsp_pkg::T_OPFETCH;
      fetchReg    <= 1'b1;
      addrReg     <= plsp_pkg::RESET_PAIR;
      loByteReg   <= 8'h00;
      popReg      <= 1'b0;
      progCounter <= plsp_pkg::RESET_PAIR;
      instrDone   <= 1'b0;
      illegalOp   <= 1'b0;
    end else begin
      instrDone <= 1'b0;
      illegalOp <= 1'b0;
      if (cycleEnd) begin
        case (stateReg)
          plsp_pkg::PLSP_IDLE: begin
            // opcode fetch just finished (4 states)
            progCounter <= progCounter + 16'h0001;
            fetchReg    <= 1'b0;
            if (memData == plsp_pkg::OPC_LOAD_PRIMARY) begin
              // absolute load: two operand bytes, then two data bytes
              popReg   <= 1'b0;
              destReg  <= plsp_pkg::PLSP_PRIMARY;
              stateReg <= plsp_pkg::PLSP_OPN_LO;
              tlenReg  <= plsp_pkg::T_MEMRD;
            end else if ((memData & plsp_pkg::OPC_POP_MASK) == plsp_pkg::OPC_POP_BASE) begin
              // single-byte pop: the select field picks the pair, even the primary one
              popReg   <= 1'b1;
              destReg  <= plsp_pkg::plsp_dest_e'({1'b0, memData[plsp_pkg::POP_SEL_LSB +: 2]});
              addrReg  <= regs.stackPointerReg;
              stateReg <= plsp_pkg::PLSP_DATA_LO;
              tlenReg  <= plsp_pkg::T_MEMRD;
            end else if (memData == plsp_pkg::OPC_PREFIX_FIRST_IDX ||
                         memData == plsp_pkg::OPC_PREFIX_SECOND_IDX) begin
              destReg  <= memData[plsp_pkg::IDX_SEL_BIT] ? plsp_pkg::PLSP_IDX_SECOND
                                                          : plsp_pkg::PLSP_IDX_FIRST;
              // index pop moves the pointer like any other pop
              popReg   <= 1'b1;
              stateReg <= plsp_pkg::PLSP_PREFIX;
              tlenReg  <= plsp_pkg::T_OPFETCH;
            end else if (memData == plsp_pkg::OPC_PREFIX_EXT) begin
              // alternate load prefix: same operand and data cycles after a second opcode
              popReg   <= 1'b0;
              destReg  <= plsp_pkg::PLSP_PRIMARY;
              stateReg <= plsp_pkg::PLSP_PREFIX;
              tlenReg  <= plsp_pkg::T_OPFETCH;
            end else begin
              // unsupported byte: flag it and fetch the next opcode
              illegalOp <= 1'b1;
              fetchReg  <= 1'b1;
            end
          end
          plsp_pkg::PLSP_PREFIX: begin
            // second opcode byte after a prefix (4 states)
            progCounter <= progCounter + 16'h0001;
            tlenReg     <= plsp_pkg::T_MEMRD;
            // the load prefix only takes its load byte, the index prefixes only a pop
            if (destReg == plsp_pkg::PLSP_PRIMARY && memData == plsp_pkg::OPC_EXT_LOAD_PRIMARY) begin
              stateReg <= plsp_pkg::PLSP_OPN_LO;
            end else if (destReg != plsp_pkg::PLSP_PRIMARY && memData == plsp_pkg::OPC_POP_INDEX) begin
              addrReg  <= regs.stackPointerReg;
              stateReg <= plsp_pkg::PLSP_DATA_LO;
            end else begin
              // any other second byte is refused like an unknown opcode
              illegalOp <= 1'b1;
              stateReg  <= plsp_pkg::PLSP_IDLE;
              tlenReg   <= plsp_pkg::T_OPFETCH;
              fetchReg  <= 1'b1;
            end
          end
          plsp_pkg::PLSP_OPN_LO: begin
            // operand low byte sits at the program counter
            progCounter     <= progCounter + 16'h0001;
            addrReg[7:0]    <= memData;
            stateReg        <= plsp_pkg::PLSP_OPN_HI;
          end
          plsp_pkg::PLSP_OPN_HI: begin
            // operand high byte completes the data address
            progCounter     <= progCounter + 16'h0001;
            addrReg[15:8]   <= memData;
            stateReg        <= plsp_pkg::PLSP_DATA_LO;
          end
          plsp_pkg::PLSP_DATA_LO: begin
            // next read is one address higher and wraps at the top of memory
            loByteReg <= memData;
            addrReg   <= addrReg + 16'h0001;
            stateReg  <= plsp_pkg::PLSP_DATA_HI;
          end
          plsp_pkg::PLSP_DATA_HI: begin
            // the pair process writes the high byte at this same edge
            instrDone <= 1'b1;
            stateReg  <= plsp_pkg::PLSP_IDLE;
            tlenReg   <= plsp_pkg::T_OPFETCH;
            fetchReg  <= 1'b1;
          end
          default: begin
            // unreachable state: fall back to a fresh opcode fetch
            stateReg <= plsp_pkg::PLSP_IDLE;
            tlenReg  <= plsp_pkg::T_OPFETCH;
            fetchReg <= 1'b1;
          end
        endcase
      end
    end
  end

  // memory request: program counter for fetches and operands, else data address
  // rd is held high: this engine only reads, so a write cycle never occurs here
  always_comb begin
    memReq.rd = 1'b1;
    case (stateReg)
      plsp_pkg::PLSP_DATA_LO,
      plsp_pkg::PLSP_DATA_HI: memReq.addr = addrReg;
      default:                memReq.addr = progCounter;
    endcase
  end

  // destination pairs; flags live in accumFlagsPair low half and change only by pop
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      regs.genPairOne         <= plsp_pkg::RESET_PAIR;
      regs.genPairTwo         <= plsp_pkg::RESET_PAIR;
      regs.primaryAddressPair <= plsp_pkg::RESET_PAIR;
      regs.accumFlagsPair     <= plsp_pkg::RESET_PAIR;
      regs.firstIndexReg      <= plsp_pkg::RESET_PAIR;
      regs.secondIndexReg     <= plsp_pkg::RESET_PAIR;
      regs.stackPointerReg    <= plsp_pkg::RESET_SP;
    end else if (pairWrite) begin
      case (destReg)
        plsp_pkg::PLSP_GEN_ONE:    regs.genPairOne         <= pairValue;
        plsp_pkg::PLSP_GEN_TWO:    regs.genPairTwo         <= pairValue;
        plsp_pkg::PLSP_PRIMARY:    regs.primaryAddressPair <= pairValue;
        plsp_pkg::PLSP_ACCFLAGS:   regs.accumFlagsPair     <= pairValue;
        plsp_pkg::PLSP_IDX_FIRST:  regs.firstIndexReg      <= pairValue;
        plsp_pkg::PLSP_IDX_SECOND: regs.secondIndexReg     <= pairValue;
        default:                   regs.genPairOne         <= regs.genPairOne;
      endcase
      // pointer moves by two only as a pop completes; one process owns the whole struct
      if (popReg) begin
        regs.stackPointerReg <= regs.stackPointerReg + 16'h0002;
      end
    end
  end
endmodule

// [bench/plsp_core_monitor.sv]
// plsp_core_monitor: concurrent checks on the pair load and stack pop engine
// assumes one clk domain; bound to plsp_core through its ports only
`timescale 1ns/1ps
module plsp_core_monitor (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [7:0]             memData,
  input wire plsp_pkg::plsp_memreq_s memReq,
  input wire plsp_pkg::plsp_regs_s   regs,
  input wire logic [15:0]            progCounter,
  input wire logic                   busy,
  input wire logic                   instrDone,
  input wire logic                   illegalOp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // after each instruction or refusal the next opcode fetch reads at the program counter
  a_next_fetch: assert property ((instrDone || illegalOp) |->
    busy && memReq.rd && memReq.addr == progCounter) else $error("next fetch not at program counter");
  // program bytes are taken strictly one after another
  a_pc_step: assert property ($changed(progCounter) |-> progCounter == $past(progCounter) + 16'h0001)
    else $error("program counter skipped");
  // pointer moves only by two, and only as an instruction ends
  a_sp_step: assert property ($changed(regs.stackPointerReg) |->
    instrDone && regs.stackPointerReg == $past(regs.stackPointerReg) + 16'h0002) else $error("bad pointer step");
  // last stack read sits one above the old pointer
  a_pop_addr: assert property (instrDone && $changed(regs.stackPointerReg) |->
    $past(memReq.addr) == $past(regs.stackPointerReg) + 16'h0001) else $error("bad high byte address");
  // no pair or flag moves between instruction ends
  a_regs_at_done: assert property ($changed(regs) |-> instrDone) else $error("pair changed early");
  // shortest instruction is ten states
  a_done_spacing: assert property (instrDone |=> !instrDone [*8]) else $error("instructions too close");
  // a refused opcode costs one fetch of four states
  a_illegal_pulse: assert property (illegalOp |=> !(illegalOp || instrDone) [*3]) else $error("bad refusal");
  // an address stands for at least three states
  a_cycle_hold: assert property ($changed(memReq.addr) |=> $stable(memReq.addr) [*2])
    else $error("machine cycle too short");
endmodule
bind plsp_core plsp_core_monitor u_plsp_core_monitor (.clk(clk), .rst_b(rst_b), .memData(memData),
  .memReq(memReq), .regs(regs), .progCounter(progCounter), .busy(busy), .instrDone(instrDone),
  .illegalOp(illegalOp));

// [bench/plsp_mem_model.sv]
// plsp_mem_model: zero wait state memory holding program and stack
// assumes the bench loads mem before reset is released
`timescale 1ns/1ps
module plsp_mem_model (
  input  wire logic                   clk,
  input  wire plsp_pkg::plsp_memreq_s memReq,
  output logic [7:0]                  memData
);
  logic [7:0] mem [0:65535];
  logic [7:0] idleData = 8'hA5;
  // undriven data toggles so a stale byte never looks valid
  always @(posedge clk) idleData <= ~idleData;
  assign memData = memReq.rd ? mem[memReq.addr] : idleData;
endmodule

// [bench/plsp_core_tb.sv]
// plsp_core_tb: random program run against a decoding model of the engine
// assumes back to back instructions from address zero after reset
`timescale 1ns/1ps
module plsp_core_tb;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic [7:0]           memData, op;
  plsp_pkg::plsp_memreq_s memReq;
  plsp_pkg::plsp_regs_s regs, expRegs;
  logic [15:0]          progCounter, pc, ptr, opnAddr, stackPtr;
  logic                 busy, instrDone, illegalOp;
  logic [7:0]           img [0:65535];
  int                   bad_count = 0, compares = 0, len, gap, pick;
  always #20 clk = ~clk;
  plsp_core u_plsp_core (.clk(clk), .rst_b(rst_b), .memData(memData), .memReq(memReq), .regs(regs),
    .progCounter(progCounter), .busy(busy), .instrDone(instrDone), .illegalOp(illegalOp));
  plsp_mem_model u_plsp_mem_model (.clk(clk), .memReq(memReq), .memData(memData));
  // pairs, stack pointer and program counter against the model
  task automatic compareRegs(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected registers at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // refusal pulse against the decode of the model
  task automatic compareRefusal(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected refusal at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // clocks from one result to the next against the state counts
  task automatic compareCycles(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected cycle count at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] b);
    img[ptr] = b;
    ptr++;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(99));
    for (int a = 0; a < 65536; a++) img[a] = 8'($urandom);
    ptr = 16'h0000;
    // first nine cover every encoding, the rest are random
    for (int i = 0; i < 40; i++) begin
      pick = (i < 9) ? i : int'($urandom % 9);
      opnAddr = 16'($urandom);
      case (pick)
        0: begin put(8'h2A); put(opnAddr[7:0]); put(opnAddr[15:8]); end
        1: begin put(8'hED); put(8'h6B); put(opnAddr[7:0]); put(opnAddr[15:8]); end
        2, 3, 4, 5: put(8'hC1 + {2'(pick - 2), 4'h0});
        6: begin put(8'hDD); put(8'hE1); end
        7: begin put(8'hFD); put(8'hE1); end
        default: put(8'h00);
      endcase
    end
    u_plsp_mem_model.mem = img;
    expRegs = '0;
    expRegs.stackPointerReg = plsp_pkg::RESET_SP;
    pc = 16'h0000;
    repeat (3) @(posedge clk);
    #1;
    compareRegs({regs, progCounter}, {expRegs, pc});
    $display("reset test done");
    rst_b = 1'b1;
    for (int k = 0; k < 40; k++) begin
      op = img[pc];
      stackPtr = expRegs.stackPointerReg;
      len = 10;
      // decode from the image: low byte first, high byte at address plus one
      if (op == 8'h2A || op == 8'hED) begin
        opnAddr = (op == 8'h2A) ? {img[pc + 16'h2], img[pc + 16'h1]} : {img[pc + 16'h3], img[pc + 16'h2]};
        expRegs.primaryAddressPair = {img[opnAddr + 16'h1], img[opnAddr]};
        len = (op == 8'h2A) ? 16 : 20;
        pc = pc + ((op == 8'h2A) ? 16'h3 : 16'h4);
      end else if (op == 8'hDD || op == 8'hFD) begin
        if (op[5]) expRegs.secondIndexReg = {img[stackPtr + 16'h1], img[stackPtr]};
        else expRegs.firstIndexReg = {img[stackPtr + 16'h1], img[stackPtr]};
        len = 14;
        pc = pc + 16'h2;
      end else if (op[3:0] == 4'h1 && op[7:6] == 2'h3) begin
        case (op[5:4])
          2'h0: expRegs.genPairOne = {img[stackPtr + 16'h1], img[stackPtr]};
          2'h1: expRegs.genPairTwo = {img[stackPtr + 16'h1], img[stackPtr]};
          2'h2: expRegs.primaryAddressPair = {img[stackPtr + 16'h1], img[stackPtr]};
          default: expRegs.accumFlagsPair = {img[stackPtr + 16'h1], img[stackPtr]};
        endcase
        pc = pc + 16'h1;
      end else begin
        len = 4;
        pc = pc + 16'h1;
      end
      if (len != 4 && op != 8'h2A && op != 8'hED) expRegs.stackPointerReg = stackPtr + 16'h2;
      gap = 0;
      do begin
        @(posedge clk);
        #1;
        gap++;
      end while (!(instrDone === 1'b1 || illegalOp === 1'b1) && gap < 40);
      if (gap >= 40) begin
        // a hung engine counts as a mismatch and goes straight to the verdict
        bad_count++;
        break;
      end
      compareRegs({regs, progCounter}, {expRegs, pc});
      compareRefusal(illegalOp, len == 4);
      // the first result also carries the two clocks of the reset synchroniser
      if (k > 0) compareCycles(gap, len);
      else compareCycles(gap, len + 2);
    end
    $display("program test done");
    summarize();
  end
endmodule
